// >>> rtl/ifr_ctrl.sv
/*
 * ifr_ctrl: serial loaded if reference control word, rx and tx reference
 * dividers with lock filters, and the multiplexed lock pin.
 * assumes: serial clock, data, strobe, reference and comparator inputs are
 * pins and get synchronised; n counter, rf taps and powerdowns come from
 * logic on clk_in.
 */
//
// Overview of operation
// (RQ1) address 001 plus strobe rise loads word
// (RQ2) 10-bit ratios divide by value, 2..1023
// (RQ3) bit above address is ignored
// (RQ4) data bit 18 sets tx polarity
// (RQ5) data bit 17 holds tx counters reset
// (RQ6) data bits 16..13 pick lock pin source
// (RQ7) codes 0, 1: digital, analog lock, open-drain
// (RQ8) lock is AND of active plls
// (RQ9) codes 1000..1110 drive counter taps, cmos
// (RQ10) host never programs code 1111
// (RQ11) lock after five cycles under 15 ns
// (RQ12) locked window 30 ns, exceeding it unlocks
// (RQ13) powered down pll reads as locked
// (RQ14) data bit 2 sets rx polarity
// (RQ15) data bit 1 holds rx counters reset
// (RQ16) shift layout: address, x, rx, selector, tx
// (RQ17) error before lock restarts the count
`timescale 1ns/1ps
`default_nettype none
`include "ifr_params.svh"
module ifr_ctrl #(
   parameter int RATIO_W = 10
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // serial link pins
   input wire logic ser_clk_in,
   input wire logic ser_data_in,
   input wire logic load_strobe_in,
   // reference and delay comparator pins
   input wire logic ref_osc_in,
   input wire logic rx_err_over_entry_in,
   input wire logic rx_err_over_hold_in,
   input wire logic tx_err_over_entry_in,
   input wire logic tx_err_over_hold_in,
   input wire logic analog_lock_in,
   // neighbour logic
   input wire logic rx_pwdn_in,
   input wire logic tx_pwdn_in,
   input wire logic rf_pwdn_in,
   input wire logic rf_lock_in,
   input wire logic rx_fb_tap_in,
   input wire logic tx_fb_tap_in,
   input wire logic rf_ref_tap_in,
   input wire logic rf_fb_tap_in,
   input wire logic rf_fastlock_tap_in,
   // control outputs
   output logic [RATIO_W-1:0] rx_ref_divider_ratio_out,
   output logic [RATIO_W-1:0] tx_ref_divider_ratio_out,
   output logic rx_detector_polarity_out,
   output logic tx_detector_polarity_out,
   output logic rx_cnt_reset_out,
   output logic tx_cnt_reset_out,
   output logic rx_ref_tap_out,
   output logic tx_ref_tap_out,
   // multiplexed lock pin
   output logic lock_pin_out,
   output logic lock_pin_oe_out
);
   localparam int NPIN = 9;
   logic [NPIN-1:0] pin_raw, s1_r, s2_r, s3_r;
   logic [31:0] sr_r, sr_nxt, word_r, word_nxt;
   logic ser_rise, strobe_rise, ref_rise;
   logic [1:0] ch_tap, ch_lock, ch_rst, ch_pwdn, ch_entry, ch_hold;
   logic [RATIO_W-1:0] ch_ratio [2];
   ifr_pkg::ifr_sel_t lock_pin_selector;
   logic lock_all, pin_nxt, oe_nxt;

   assign pin_raw = {analog_lock_in, tx_err_over_hold_in,
      tx_err_over_entry_in, rx_err_over_hold_in, rx_err_over_entry_in,
      ref_osc_in, load_strobe_in, ser_data_in, ser_clk_in};

   // two-stage synchronisers, third stage only for edge finding
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign ser_rise = s2_r[0] && !s3_r[0];
   assign strobe_rise = s2_r[2] && !s3_r[2];
   assign ref_rise = s2_r[3] && !s3_r[3];

   // shift register and word load
   always_comb
   begin
      sr_nxt = sr_r;
      word_nxt = word_r;
      if (ser_rise)
         sr_nxt = {sr_r[30:0], s2_r[1]};
      if (strobe_rise && sr_r[`IFR_ADDR_MSB:0] == `IFR_ADDR_CODE) // RQ1
      begin
         word_nxt = sr_r; // RQ16
         word_nxt[`IFR_DONT_CARE_BIT] = 1'b0; // RQ3
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         sr_r <= 32'h0000_0000;
         word_r <= `IFR_WORD_RESET;
      end
      else
      begin
         sr_r <= sr_nxt;
         word_r <= word_nxt;
      end
   end

   assign lock_pin_selector = word_r[`IFR_SEL_MSB:`IFR_SEL_LSB]; // RQ6
   assign ch_ratio[0] = word_r[`IFR_RX_RATIO_MSB:`IFR_RX_RATIO_LSB];
   assign ch_ratio[1] = word_r[`IFR_TX_RATIO_MSB:`IFR_TX_RATIO_LSB];
   assign ch_rst = {word_r[`IFR_TX_RST_BIT], word_r[`IFR_RX_RST_BIT]};
   assign ch_pwdn = {tx_pwdn_in, rx_pwdn_in};
   assign ch_entry = {s2_r[6], s2_r[4]};
   assign ch_hold = {s2_r[7], s2_r[5]};

   // rx is channel 0, tx is channel 1
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_ch
         ifr_pll_channel #(
            .RATIO_W(RATIO_W)
         ) u_ch (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .ref_edge_in(ref_rise),
            .ratio_in(ch_ratio[i]),
            .cnt_reset_in(ch_rst[i]),
            .pwdn_in(ch_pwdn[i]),
            .err_over_entry_in(ch_entry[i]),
            .err_over_hold_in(ch_hold[i]),
            .ref_tap_out(ch_tap[i]),
            .lock_out(ch_lock[i])
         );
      end
   endgenerate

   // powered down channels already read high
   assign lock_all = &ch_lock && (rf_pwdn_in || rf_lock_in); // RQ8

   always_comb
   begin
      pin_nxt = 1'b0;
      oe_nxt = 1'b0;
      unique case (lock_pin_selector)
         `IFR_SEL_DIGITAL: oe_nxt = !lock_all; // RQ7
         `IFR_SEL_ANALOG: oe_nxt = !s2_r[8]; // RQ7
         `IFR_SEL_RX_REF: {oe_nxt, pin_nxt} = {1'b1, ch_tap[0]}; // RQ9
         `IFR_SEL_RX_FB: {oe_nxt, pin_nxt} = {1'b1, rx_fb_tap_in};
         `IFR_SEL_TX_REF: {oe_nxt, pin_nxt} = {1'b1, ch_tap[1]};
         `IFR_SEL_TX_FB: {oe_nxt, pin_nxt} = {1'b1, tx_fb_tap_in};
         `IFR_SEL_RF_REF: {oe_nxt, pin_nxt} = {1'b1, rf_ref_tap_in};
         `IFR_SEL_RF_FB: {oe_nxt, pin_nxt} = {1'b1, rf_fb_tap_in};
         `IFR_SEL_RF_FASTLOCK:
            {oe_nxt, pin_nxt} = {1'b1, rf_fastlock_tap_in};
         // factory test and unused codes release the pin
         `IFR_SEL_RF_TEST: oe_nxt = 1'b0; // RQ10
         default: oe_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         rx_ref_divider_ratio_out <= '0;
         tx_ref_divider_ratio_out <= '0;
         rx_detector_polarity_out <= 1'b0;
         tx_detector_polarity_out <= 1'b0;
         rx_cnt_reset_out <= 1'b0;
         tx_cnt_reset_out <= 1'b0;
         rx_ref_tap_out <= 1'b0;
         tx_ref_tap_out <= 1'b0;
         lock_pin_out <= 1'b0;
         lock_pin_oe_out <= 1'b0;
      end
      else
      begin
         rx_ref_divider_ratio_out <= ch_ratio[0];
         tx_ref_divider_ratio_out <= ch_ratio[1];
         rx_detector_polarity_out <= word_r[`IFR_RX_POL_BIT]; // RQ14
         tx_detector_polarity_out <= word_r[`IFR_TX_POL_BIT]; // RQ4
         rx_cnt_reset_out <= word_r[`IFR_RX_RST_BIT]; // RQ15
         tx_cnt_reset_out <= word_r[`IFR_TX_RST_BIT]; // RQ5
         rx_ref_tap_out <= ch_tap[0];
         tx_ref_tap_out <= ch_tap[1];
         lock_pin_out <= pin_nxt;
         lock_pin_oe_out <= oe_nxt;
      end
   end

   a_load_match: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      strobe_rise && sr_r[2:0] == `IFR_ADDR_CODE
      |=> word_r[31:4] == $past(sr_r[31:4])) // RQ1
      else $error("word not loaded on matching address");
   a_load_other: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      strobe_rise && sr_r[2:0] != `IFR_ADDR_CODE |=> $stable(word_r)) // RQ1
      else $error("word changed on foreign address");
   a_dont_care: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !word_r[`IFR_DONT_CARE_BIT]) // RQ3
      else $error("ignored bit reached the word");
   a_pol_tx: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $changed(word_r[21]) |=> tx_detector_polarity_out == $past(word_r[21]))
      // RQ4
      else $error("tx polarity does not follow word");
   a_tx_rst_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      word_r[`IFR_TX_RST_BIT] [*2] |-> !ch_tap[1]) // RQ5
      else $error("tx divider runs under reset");
   a_rx_rst_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      word_r[`IFR_RX_RST_BIT] [*2] |-> !ch_tap[0] && rx_cnt_reset_out) // RQ15
      else $error("rx divider runs under reset");
   a_pin_digital: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      lock_pin_selector == `IFR_SEL_DIGITAL
      |=> !lock_pin_out && lock_pin_oe_out == !$past(lock_all)) // RQ7 RQ8
      else $error("digital lock pin wrong");
   a_pin_cmos: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      lock_pin_selector == `IFR_SEL_TX_REF
      |=> lock_pin_oe_out && lock_pin_out == $past(ch_tap[1])) // RQ9
      else $error("counter tap not on pin");
   a_pin_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      lock_pin_selector inside {4'h2, 4'h7, `IFR_SEL_RF_TEST}
      |=> !lock_pin_oe_out) // RQ6
      else $error("pin driven on unused code");
   c_load: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      strobe_rise && sr_r[2:0] == `IFR_ADDR_CODE);
   c_cmos: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      lock_pin_oe_out && lock_pin_out);
   c_all_lock: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      !lock_all ##1 lock_all);
endmodule
`default_nettype wire

// >>> rtl/ifr_params.svh
/*
 * ifr_params.svh: field positions, codes, reset value and counts of the
 * if reference control word.
 * assumes: included by bare name from the rtl files; definitions only.
 */
`ifndef IFR_PARAMS_SVH
`define IFR_PARAMS_SVH
`define IFR_ADDR_MSB 2
`define IFR_ADDR_CODE 3'h1
`define IFR_DONT_CARE_BIT 3
`define IFR_RX_RST_BIT 4
`define IFR_RX_POL_BIT 5
`define IFR_RX_RATIO_LSB 6
`define IFR_RX_RATIO_MSB 15
`define IFR_SEL_LSB 16
`define IFR_SEL_MSB 19
`define IFR_TX_RST_BIT 20
`define IFR_TX_POL_BIT 21
`define IFR_TX_RATIO_LSB 22
`define IFR_TX_RATIO_MSB 31
`define IFR_WORD_RESET 32'h0000_0000
`define IFR_RATIO_MIN 10'h002
`define IFR_LOCK_QUAL_CYCLES 5
`define IFR_SEL_DIGITAL 4'h0
`define IFR_SEL_ANALOG 4'h1
`define IFR_SEL_RX_REF 4'h8
`define IFR_SEL_RX_FB 4'h9
`define IFR_SEL_TX_REF 4'ha
`define IFR_SEL_TX_FB 4'hb
`define IFR_SEL_RF_REF 4'hc
`define IFR_SEL_RF_FB 4'hd
`define IFR_SEL_RF_FASTLOCK 4'he
`define IFR_SEL_RF_TEST 4'hf
`endif

// >>> rtl/ifr_pkg.sv
/*
 * ifr_pkg: types shared by the if reference control block.
 * assumes: compiled before the modules that use it.
 */
package ifr_pkg;
   typedef enum logic {IFR_SEEK, IFR_LOCKED} ifr_lock_e;
   typedef logic [3:0] ifr_sel_t;
endpackage

// >>> rtl/ifr_pll_channel.sv
/*
 * ifr_pll_channel: one if reference divider with its digital lock filter.
 * assumes: ref_edge_in is a one-cycle pulse per reference input edge, the
 * error flags come already synchronised from the delay comparators.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ifr_params.svh"
module ifr_pll_channel #(
   parameter int RATIO_W = 10,
   parameter logic [2:0] QUAL = 3'(`IFR_LOCK_QUAL_CYCLES)
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // control
   input wire logic ref_edge_in,
   input wire logic [RATIO_W-1:0] ratio_in,
   input wire logic cnt_reset_in,
   input wire logic pwdn_in,
   input wire logic err_over_entry_in,
   input wire logic err_over_hold_in,
   // results
   output logic ref_tap_out,
   output logic lock_out
);
   logic [RATIO_W-1:0] cnt_r, cnt_nxt;
   logic [2:0] qual_r, qual_nxt;
   ifr_pkg::ifr_lock_e st_r, st_nxt;
   logic tap_nxt, lock_nxt, hold, tick;

   always_comb
   begin
      cnt_nxt = cnt_r;
      qual_nxt = qual_r;
      st_nxt = st_r;
      hold = cnt_reset_in || (ratio_in < RATIO_W'(`IFR_RATIO_MIN));
      tick = 1'b0;
      if (hold)
      begin
         cnt_nxt = '0; // RQ5 RQ15
      end
      else if (ref_edge_in)
      begin
         // divide by plain binary ratio
         tick = (cnt_r == RATIO_W'(1)); // RQ2
         if (cnt_r == '0)
            cnt_nxt = ratio_in - RATIO_W'(1);
         else
            cnt_nxt = cnt_r - RATIO_W'(1);
      end
      if (pwdn_in)
      begin
         st_nxt = ifr_pkg::IFR_SEEK;
         qual_nxt = 3'h0;
      end
      else if (tick)
      begin
         unique case (st_r)
            ifr_pkg::IFR_SEEK:
            begin
               if (err_over_entry_in)
                  qual_nxt = 3'h0; // RQ17
               else if (qual_r == QUAL - 3'h1)
               begin
                  st_nxt = ifr_pkg::IFR_LOCKED; // RQ11
                  qual_nxt = 3'h0;
               end
               else
                  qual_nxt = qual_r + 3'h1;
            end
            ifr_pkg::IFR_LOCKED:
            begin
               if (err_over_hold_in)
                  st_nxt = ifr_pkg::IFR_SEEK; // RQ12
            end
         endcase
      end
      tap_nxt = !hold && (cnt_nxt == '0);
      lock_nxt = pwdn_in || (st_nxt == ifr_pkg::IFR_LOCKED); // RQ13
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         cnt_r <= '0;
         qual_r <= 3'h0;
         st_r <= ifr_pkg::IFR_SEEK;
         ref_tap_out <= 1'b0;
         lock_out <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         qual_r <= qual_nxt;
         st_r <= st_nxt;
         ref_tap_out <= tap_nxt;
         lock_out <= lock_nxt;
      end
   end

   a_pwdn_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pwdn_in |=> lock_out) // RQ13
      else $error("lock not forced high in powerdown");
   a_qual_five: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (st_r == ifr_pkg::IFR_SEEK) ##1 (st_r == ifr_pkg::IFR_LOCKED)
      |-> $past(qual_r) == QUAL - 3'h1) // RQ11
      else $error("lock entered before five clean cycles");
   a_unlock_wide: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      st_r == ifr_pkg::IFR_LOCKED && tick && err_over_hold_in && !pwdn_in
      |=> !lock_out) // RQ12
      else $error("lock kept past wide window");
   a_qual_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      st_r == ifr_pkg::IFR_SEEK && tick && err_over_entry_in && !pwdn_in
      |=> qual_r == 3'h0 && !lock_out) // RQ17
      else $error("qualification not restarted");
   a_div_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      hold |=> cnt_r == '0 && !ref_tap_out) // RQ2
      else $error("divider runs with illegal ratio or reset");
   c_lock_gain: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      !pwdn_in && st_r == ifr_pkg::IFR_SEEK ##1 st_r == ifr_pkg::IFR_LOCKED);
endmodule
`default_nettype wire

// >>> tb/ifr_host.sv
/* ifr_host: host model that shifts words into the block and strobes them.
   assumes: clk_in is the bench clock at 100 ns; serial period is 8 cycles. */
`timescale 1ns/1ps
`default_nettype none
module ifr_host (
   // clock
   input wire logic clk_in,
   // serial link
   output logic ser_clk_out,
   output logic ser_data_out,
   output logic load_strobe_out
);
   initial
   begin
      ser_clk_out = 1'b0;
      ser_data_out = 1'b0;
      load_strobe_out = 1'b0;
   end
   // msb first, serial clock idles low outside frames
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         ser_data_out <= w[i];
         repeat (4) @(posedge clk_in);
         ser_clk_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         ser_clk_out <= 1'b0;
      end
      repeat (4) @(posedge clk_in);
      ser_data_out <= ~w[0];
      load_strobe_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      load_strobe_out <= 1'b0;
      @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// >>> tb/ifr_ctrl_tb.sv
/* ifr_ctrl_tb: loads control words through the host model and checks the
   decoded outputs, the lock pin selector and the lock filter.
   assumes: design files compiled first; no other stimulus source. */
`timescale 1ns/1ps
`default_nettype none
module ifr_ctrl_tb;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ser_clk, ser_data, strobe;
   logic [1:0] ref_cnt = 2'h0;
   logic rx_eo = 1'b1, rx_ho = 1'b1, tx_eo = 1'b0, tx_ho = 1'b0;
   logic alock = 1'b0, rf_lock = 1'b0;
   logic rx_pd = 1'b0, tx_pd = 1'b0, rf_pd = 1'b0;
   logic [4:0] taps = 5'h00;
   logic [9:0] rx_ratio, tx_ratio;
   logic rx_pol, tx_pol, rx_rst, tx_rst, pin, oe;
   logic rx_tap, tx_tap;
   int n_rx, n_tx, n_pin;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;

   always #50 clk_in = ~clk_in;
   always @(posedge clk_in) ref_cnt <= ref_cnt + 2'h1;

   ifr_host u_host (.clk_in(clk_in), .ser_clk_out(ser_clk),
      .ser_data_out(ser_data), .load_strobe_out(strobe));

   ifr_ctrl #(.RATIO_W(10)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .ser_clk_in(ser_clk), .ser_data_in(ser_data),
      .load_strobe_in(strobe), .ref_osc_in(ref_cnt[1]),
      .rx_err_over_entry_in(rx_eo), .rx_err_over_hold_in(rx_ho),
      .tx_err_over_entry_in(tx_eo), .tx_err_over_hold_in(tx_ho),
      .analog_lock_in(alock), .rx_pwdn_in(rx_pd), .tx_pwdn_in(tx_pd),
      .rf_pwdn_in(rf_pd), .rf_lock_in(rf_lock), .rx_fb_tap_in(taps[0]),
      .tx_fb_tap_in(taps[1]), .rf_ref_tap_in(taps[2]),
      .rf_fb_tap_in(taps[3]), .rf_fastlock_tap_in(taps[4]),
      .rx_ref_divider_ratio_out(rx_ratio),
      .tx_ref_divider_ratio_out(tx_ratio),
      .rx_detector_polarity_out(rx_pol),
      .tx_detector_polarity_out(tx_pol), .rx_cnt_reset_out(rx_rst),
      .tx_cnt_reset_out(tx_rst), .rx_ref_tap_out(rx_tap),
      .tx_ref_tap_out(tx_tap),
      .lock_pin_out(pin), .lock_pin_oe_out(oe));

   task automatic close_out();
      if (err_total == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // bit 3 always set so that the ignored bit is exercised
   function automatic logic [31:0] mk(input logic [9:0] txr,
      input logic txp, input logic txs, input logic [3:0] sel,
      input logic [9:0] rxr, input logic rxp, input logic rxs,
      input logic [2:0] a);
      return {txr, txp, txs, sel, rxr, rxp, rxs, 1'b1, a};
   endfunction

   task automatic load(input logic [31:0] w);
      u_host.send(w);
      repeat (8) @(posedge clk_in);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 12000)
      begin
         err_total++;
         close_out();
      end
   end

   initial
   begin
      cyc(20);
      rst_n_in <= 1'b1;
      cyc(3);
      chk({22'h0, rx_ratio}, 32'h0);
      chk({30'h0, oe, pin}, 32'h2);
      load(mk(10'h002, 1'b0, 1'b1, 4'h8, 10'h3ff, 1'b1, 1'b0, 3'h1));
      chk({22'h0, rx_ratio}, 32'h3ff);
      chk({22'h0, tx_ratio}, 32'h2);
      chk({28'h0, tx_pol, tx_rst, rx_pol, rx_rst}, 32'h6);
      load(mk(10'h155, 1'b1, 1'b0, 4'h0, 10'h0aa, 1'b0, 1'b1, 3'h2));
      chk({22'h0, rx_ratio}, 32'h3ff);
      chk({28'h0, tx_pol, tx_rst, rx_pol, rx_rst}, 32'h6);
      load(mk(10'h155, 1'b1, 1'b0, 4'h0, 10'h0aa, 1'b0, 1'b1, 3'h1));
      chk({22'h0, tx_ratio}, 32'h155);
      chk({28'h0, tx_pol, tx_rst, rx_pol, rx_rst}, 32'h9);
      // host never asks for code f
      for (int c = 8; c <= 14; c++)
      begin
         load(mk(10'h0, 1'b0, 1'b1, 4'(c), 10'h0, 1'b0, 1'b1, 3'h1));
         for (int v = 0; v < 2; v++)
         begin
            taps <= {5{v[0]}};
            cyc(3);
            chk({30'h0, oe, pin},
               {30'h0, 1'b1, (c == 8 || c == 10) ? 1'b0 : v[0]});
         end
      end
      // reserved code releases the pin
      load(mk(10'h0, 1'b0, 1'b1, 4'h2, 10'h0, 1'b0, 1'b1, 3'h1));
      chk({30'h0, oe, pin}, 32'h0);
      load(mk(10'h0, 1'b0, 1'b1, 4'h1, 10'h0, 1'b0, 1'b1, 3'h1));
      alock <= 1'b0;
      cyc(3);
      chk({30'h0, oe, pin}, 32'h2);
      // analog level passes two sync stages before the pin register
      alock <= 1'b1;
      cyc(4);
      chk({31'h0, oe}, 32'h0);
      tx_pd <= 1'b1;
      rf_pd <= 1'b1;
      load(mk(10'h0, 1'b1, 1'b0, 4'h0, 10'h002, 1'b1, 1'b0, 3'h1));
      cyc(80);
      chk({31'h0, oe}, 32'h1);
      rx_eo <= 1'b0;
      rx_ho <= 1'b0;
      cyc(24);
      rx_eo <= 1'b1;
      cyc(12);
      rx_eo <= 1'b0;
      cyc(24);
      chk({31'h0, oe}, 32'h1);
      cyc(80);
      chk({31'h0, oe}, 32'h0);
      rx_eo <= 1'b1;
      cyc(40);
      chk({31'h0, oe}, 32'h0);
      tx_pd <= 1'b0;
      cyc(3);
      chk({31'h0, oe}, 32'h1);
      tx_pd <= 1'b1;
      rf_pd <= 1'b0;
      cyc(3);
      chk({31'h0, oe}, 32'h1);
      rf_lock <= 1'b1;
      cyc(3);
      chk({31'h0, oe}, 32'h0);
      rx_ho <= 1'b1;
      cyc(24);
      chk({31'h0, oe}, 32'h1);
      rx_pd <= 1'b1;
      cyc(4);
      chk({31'h0, oe}, 32'h0);
      // rx divides by 2, tx by 3, pin carries the tx reference tap
      load(mk(10'h003, 1'b0, 1'b0, 4'ha, 10'h002, 1'b0, 1'b0, 3'h1));
      n_rx = 0;
      n_tx = 0;
      n_pin = 0;
      // reference edge every 4 cycles: tap high 4 cycles per period
      repeat (48)
      begin
         @(posedge clk_in);
         n_rx += int'(rx_tap);
         n_tx += int'(tx_tap);
         n_pin += int'(pin);
      end
      chk(32'(n_rx), 32'h18);
      chk(32'(n_tx), 32'h10);
      chk(32'(n_pin), 32'h10);
      chk({31'h0, oe}, 32'h1);
      close_out();
   end
endmodule
`default_nettype wire
